// ---- awcb_consts.svh ----
// Offsets, field positions, reset values and timing counts of the wake block
//==========================================================================
// Behaviour
// - Low-pass corner code bits 2..0 of 0x2 pick 1k for 000, 2k 100, 4k 101, 6k 110, 8k 111.
// - High-pass corner code bits 4..3 of 0x2 pick 200, 300, 400 and 800 Hz for 00..11.
// - With quick count 01, quick adaptation engages after two same-direction gain steps.
// - Once quick adaptation engages the loop update clock runs sixteen times faster.
// - Bit 5 of 0x4 sets the loop sampling interval, 1 s when low and 0.5 s when high.
// - The adaptive gain code never steps above the ceiling or below the floor.
// - The trigger margin code sets the trip level to code plus one times background.
// - Self-test is entered only with the mode pin low and the self-test enable set.
// - In self-test, polarity 0 holds common mode and polarity 1 toggles at 1 kHz.
// - With the mode pin low, the control mode bit picks normal (0) or hibernate (1).
// - Wake latches high until the mode pin rises or the clear bit is set, or follows the comparator if raw.
`ifndef AWCB_CONSTS_SVH
`define AWCB_CONSTS_SVH

//==========================================================================
// Register offsets
`define AWCB_OFS_CTRL 3'h0
`define AWCB_OFS_GAIN 3'h1
`define AWCB_OFS_FILT 3'h2
`define AWCB_OFS_FLOOR 3'h3
`define AWCB_OFS_CEIL 3'h4
`define AWCB_OFS_MARGIN 3'h5
`define AWCB_OFS_STEST 3'h6

//==========================================================================
// Field positions
`define AWCB_CTRL_MODE 5
`define AWCB_CTRL_CLEAR 4
`define AWCB_CTRL_RAW 3
`define AWCB_FILT_HPF_LSB 3
`define AWCB_FLOOR_QCNT_LSB 5
`define AWCB_CEIL_RATE 5
`define AWCB_STEST_POL 1
`define AWCB_STEST_EN 0

//==========================================================================
// Reset values
`define AWCB_RST_CTRL 8'h00
`define AWCB_RST_FILT 8'h00
`define AWCB_RST_FLOOR 8'h00
`define AWCB_RST_CEIL 8'h1B
`define AWCB_RST_MARGIN 8'h00
`define AWCB_RST_STEST 8'h00
`define AWCB_RST_GAIN 5'h1B

//==========================================================================
// Timing
`define AWCB_CLK_KHZ 32'h0000_9C40
`define AWCB_CLK_MHZ 32'h0000_0028
`define AWCB_SLOW_MS 32'h0000_03E8
`define AWCB_QUICK_DIV 32'h0000_0010
`define AWCB_ST_HALF_US 32'h0000_01F4

`endif

// ---- awcb_host.sv ----
// Host model: writes and reads the register port on the link clock
`timescale 1ns/10ps
module awcb_host (
   input wire logic link_clk_i,
   output logic reg_wr_o,
   output logic [2:0] reg_addr_o,
   output logic [7:0] reg_wdata_o
);
   //==========
   // Idle data is inverted so a stale byte never looks valid
   initial begin
      reg_wr_o = 1'b0;
      reg_addr_o = 3'h0;
      reg_wdata_o = 8'h00;
   end
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge link_clk_i);
      reg_wr_o <= 1'b1;
      reg_addr_o <= a;
      reg_wdata_o <= d;
      @(posedge link_clk_i);
      reg_wr_o <= 1'b0;
      reg_wdata_o <= ~d;
   endtask
   // Read data is registered, so it shows one link edge late
   task automatic rd(input logic [2:0] a);
      @(posedge link_clk_i);
      reg_addr_o <= a;
      @(posedge link_clk_i);
      #1;
   endtask
endmodule

// ---- awcb_pkg.sv ----
// Types shared by the wake configuration block
package awcb_pkg;
   typedef enum logic [2:0] {
      LPF_1K, LPF_2K, LPF_4K, LPF_6K, LPF_8K
   } awcb_lpf_t;
   typedef enum logic [1:0] {
      HPF_200, HPF_300, HPF_400, HPF_800
   } awcb_hpf_t;
   typedef enum logic [1:0] {
      ST_OFF, ST_HOLD, ST_TOGGLE
   } awcb_st_t;
   typedef logic [47:0] awcb_cfg_t;
endpackage

// ---- awcb_tick_gen.sv ----
// Update tick generator of the adaptive loop
`timescale 1ns/10ps
module awcb_tick_gen (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   awcb_tick_if.gen tif
);
   logic [31:0] cnt_r;

   //==========================================================================
   // Free count; a shrinking limit fires at once instead of overrunning
   always_ff @(posedge sys_clk_i) begin
      if (srst_i || !tif.run) begin
         cnt_r <= 32'h0000_0000;
         tif.tick <= 1'b0;
      end else if (cnt_r >= tif.lim - 32'h0000_0001) begin
         cnt_r <= 32'h0000_0000;
         tif.tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h0000_0001;
         tif.tick <= 1'b0;
      end
   end

   AST_TICK_PULSE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (tif.tick && tif.lim > 32'h0000_0001) |=> !tif.tick)
      else $error("update tick lasted more than one cycle");
endmodule

// ---- awcb_tick_if.sv ----
// Carrier between the loop logic and its update tick generator
`timescale 1ns/10ps
interface awcb_tick_if;
   logic [31:0] lim;
   logic run;
   logic tick;
   modport gen (input lim, input run, output tick);
   modport user (output lim, output run, input tick);
endinterface

// ---- awcb_top.sv ----
// Wake-path configuration registers, adaptive gain loop and self-test control
`timescale 1ns/10ps
`include "awcb_consts.svh"
module awcb_top #(
   parameter int unsigned SLOW_CYC = `AWCB_SLOW_MS * `AWCB_CLK_KHZ,
   parameter int unsigned QUICK_DIV = `AWCB_QUICK_DIV,
   parameter int unsigned ST_HALF_CYC = `AWCB_ST_HALF_US * `AWCB_CLK_MHZ
) (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic link_clk_i,
   input wire logic reg_wr_i,
   input wire logic [2:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic mode_pin_i,
   input wire logic win_above_i,
   input wire logic win_below_i,
   input wire logic wake_cmp_i,
   output logic [7:0] reg_rdata_o,
   output awcb_pkg::awcb_lpf_t lpf_corner_o,
   output awcb_pkg::awcb_hpf_t hpf_corner_o,
   output logic [3:0] margin_mult_o,
   output logic [4:0] gain_code_o,
   output logic quick_adapt_o,
   output logic hibernate_o,
   output logic wake_o,
   output logic st_active_o,
   output logic st_hold_cm_o,
   output logic st_toggle_o
);
   import awcb_pkg::*;

   //==========================================================================
   // Decoders
   function automatic awcb_lpf_t lpf_dec(input logic [2:0] c);
      awcb_lpf_t r;
      case (c)
         3'h4: r = LPF_2K;
         3'h5: r = LPF_4K;
         3'h6: r = LPF_6K;
         3'h7: r = LPF_8K;
         default: r = LPF_1K; // Unlisted codes fall back to the slowest
      endcase
      return r;
   endfunction

   function automatic logic [4:0] gray_to_bin(input logic [4:0] g);
      logic [4:0] b;
      b[4] = g[4];
      for (int i = 3; i >= 0; i--) begin
         b[i] = b[i + 1] ^ g[i];
      end
      return b;
   endfunction

   //==========================================================================
   // Link domain: reset crossing and register file
   logic lrst_q1_r;
   logic lrst_q2_r;
   logic [5:0] ctrl_r;
   logic [4:0] filt_r;
   logic [6:0] floor_r;
   logic [5:0] ceil_r;
   logic [2:0] margin_r;
   logic [1:0] stest_r;
   logic wr_hit;
   logic [4:0] gray_q1_r;
   logic [4:0] gray_q2_r;
   logic [4:0] gain_gray_r;
   awcb_cfg_t cfg_link;
   awcb_cfg_t cfg_s;

   // Reset only takes effect while the link clock runs
   always_ff @(posedge link_clk_i) begin
      lrst_q1_r <= srst_i;
      lrst_q2_r <= lrst_q1_r;
   end

   // Gain readback crosses gray-coded, one bit changes per step
   always_ff @(posedge link_clk_i) begin
      gray_q1_r <= gain_gray_r;
      gray_q2_r <= gray_q1_r;
   end

   assign wr_hit = reg_wr_i && reg_addr_i != `AWCB_OFS_GAIN &&
                   reg_addr_i <= `AWCB_OFS_STEST;

   // Writes to the read-only gain or unmapped space are dropped
   always_ff @(posedge link_clk_i) begin
      if (lrst_q2_r) begin
         ctrl_r <= 6'(`AWCB_RST_CTRL);
         filt_r <= 5'(`AWCB_RST_FILT);
         floor_r <= 7'(`AWCB_RST_FLOOR);
         ceil_r <= 6'(`AWCB_RST_CEIL);
         margin_r <= 3'(`AWCB_RST_MARGIN);
         stest_r <= 2'(`AWCB_RST_STEST);
      end else if (reg_wr_i) begin
         if (reg_addr_i == `AWCB_OFS_CTRL) begin
            ctrl_r <= reg_wdata_i[5:0];
         end else if (reg_addr_i == `AWCB_OFS_FILT) begin
            filt_r <= reg_wdata_i[4:0];
         end else if (reg_addr_i == `AWCB_OFS_FLOOR) begin
            floor_r <= reg_wdata_i[6:0];
         end else if (reg_addr_i == `AWCB_OFS_CEIL) begin
            ceil_r <= reg_wdata_i[5:0];
         end else if (reg_addr_i == `AWCB_OFS_MARGIN) begin
            margin_r <= reg_wdata_i[2:0];
         end else if (reg_addr_i == `AWCB_OFS_STEST) begin
            stest_r <= reg_wdata_i[1:0];
         end
      end
   end

   // Read data registered; reserved bits and unmapped space read zero
   always_ff @(posedge link_clk_i) begin
      if (lrst_q2_r) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_addr_i == `AWCB_OFS_CTRL) begin
         reg_rdata_o <= {2'h0, ctrl_r};
      end else if (reg_addr_i == `AWCB_OFS_GAIN) begin
         reg_rdata_o <= {3'h0, gray_to_bin(gray_q2_r)};
      end else if (reg_addr_i == `AWCB_OFS_FILT) begin
         reg_rdata_o <= {3'h0, filt_r};
      end else if (reg_addr_i == `AWCB_OFS_FLOOR) begin
         reg_rdata_o <= {1'h0, floor_r};
      end else if (reg_addr_i == `AWCB_OFS_CEIL) begin
         reg_rdata_o <= {2'h0, ceil_r};
      end else if (reg_addr_i == `AWCB_OFS_MARGIN) begin
         reg_rdata_o <= {5'h00, margin_r};
      end else if (reg_addr_i == `AWCB_OFS_STEST) begin
         reg_rdata_o <= {6'h00, stest_r};
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   assign cfg_link = {6'h00, stest_r, 5'h00, margin_r, 2'h0, ceil_r,
                      1'h0, floor_r, 3'h0, filt_r, 2'h0, ctrl_r};

   awcb_word_sync u_cfg_sync (
      .link_clk_i(link_clk_i),
      .link_rst_i(lrst_q2_r),
      .wr_i(wr_hit),
      .data_i(cfg_link),
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .data_o(cfg_s)
   );

   //==========================================================================
   // System domain: configuration fields
   logic mode_bit;
   logic clear_bit;
   logic raw_bit;
   logic [2:0] lpf_code;
   logic [1:0] hpf_code;
   logic [4:0] floor_s;
   logic [1:0] qcnt;
   logic [4:0] ceil_s;
   logic rate_bit;
   logic [2:0] margin_code;
   logic st_pol;
   logic st_on;

   assign mode_bit = cfg_s[`AWCB_CTRL_MODE];
   assign clear_bit = cfg_s[`AWCB_CTRL_CLEAR];
   assign raw_bit = cfg_s[`AWCB_CTRL_RAW];
   assign lpf_code = cfg_s[10:8];
   assign hpf_code = cfg_s[8 + `AWCB_FILT_HPF_LSB +: 2];
   assign floor_s = cfg_s[20:16];
   assign qcnt = cfg_s[16 + `AWCB_FLOOR_QCNT_LSB +: 2];
   assign ceil_s = cfg_s[28:24];
   assign rate_bit = cfg_s[24 + `AWCB_CEIL_RATE];
   assign margin_code = cfg_s[34:32];
   assign st_pol = cfg_s[40 + `AWCB_STEST_POL];
   assign st_on = cfg_s[40 + `AWCB_STEST_EN];

   //==========================================================================
   // Pin synchronisers: mode, window above, window below, wake comparator
   logic [3:0] pin_q1_r;
   logic [3:0] pin_q2_r;
   logic mode_prev_r;
   logic mode_s;
   logic above_s;
   logic below_s;
   logic cmp_s;
   logic sense_on;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         pin_q1_r <= 4'h0;
         pin_q2_r <= 4'h0;
         mode_prev_r <= 1'b0;
      end else begin
         pin_q1_r <= {wake_cmp_i, win_below_i, win_above_i, mode_pin_i};
         pin_q2_r <= pin_q1_r;
         mode_prev_r <= pin_q2_r[0];
      end
   end

   assign mode_s = pin_q2_r[0];
   assign above_s = pin_q2_r[1];
   assign below_s = pin_q2_r[2];
   assign cmp_s = pin_q2_r[3];
   assign sense_on = !mode_s && mode_bit;

   //==========================================================================
   // Static decodes to the analog chain
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         lpf_corner_o <= LPF_1K;
         hpf_corner_o <= HPF_200;
         margin_mult_o <= 4'h1;
         hibernate_o <= 1'b0;
      end else begin
         lpf_corner_o <= lpf_dec(lpf_code);
         hpf_corner_o <= awcb_hpf_t'(hpf_code);
         margin_mult_o <= {1'b0, margin_code} + 4'h1;
         hibernate_o <= sense_on;
      end
   end

   //==========================================================================
   // Adaptive gain loop
   awcb_tick_if tif ();
   logic [31:0] base_lim;
   logic [4:0] gain_nxt;
   logic step_up;
   logic step_dn;
   logic [2:0] run_r;
   logic [2:0] run_nxt;
   logic dir_up_r;
   logic quick_nxt;

   // Half interval when the rate bit is set, sixteen times faster in quick
   always_comb begin
      base_lim = rate_bit ? SLOW_CYC / 2 : SLOW_CYC;
      tif.lim = quick_adapt_o ? base_lim / QUICK_DIV : base_lim;
      tif.run = sense_on;
   end

   awcb_tick_gen u_tick (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .tif(tif)
   );

   // Out-of-range gain is pulled back first; a step never crosses a limit
   always_comb begin
      gain_nxt = gain_code_o;
      step_up = 1'b0;
      step_dn = 1'b0;
      if (gain_code_o > ceil_s) begin
         gain_nxt = ceil_s;
      end else if (gain_code_o < floor_s) begin
         gain_nxt = floor_s;
      end else if (above_s && gain_code_o > floor_s) begin
         step_dn = 1'b1;
         gain_nxt = gain_code_o - 5'h01;
      end else if (below_s && gain_code_o < ceil_s) begin
         step_up = 1'b1;
         gain_nxt = gain_code_o + 5'h01;
      end
   end

   // Same-direction run length, saturating at seven
   always_comb begin
      run_nxt = 3'h0;
      if (step_up || step_dn) begin
         if (run_r != 3'h0 && dir_up_r == step_up) begin
            run_nxt = (run_r == 3'h7) ? run_r : run_r + 3'h1;
         end else begin
            run_nxt = 3'h1;
         end
      end
      quick_nxt = qcnt != 2'h0 && run_nxt >= {1'b0, qcnt} + 3'h1;
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         gain_code_o <= `AWCB_RST_GAIN;
         run_r <= 3'h0;
         dir_up_r <= 1'b0;
         quick_adapt_o <= 1'b0;
      end else if (!sense_on) begin
         run_r <= 3'h0;
         quick_adapt_o <= 1'b0;
      end else if (tif.tick) begin
         gain_code_o <= gain_nxt;
         run_r <= run_nxt;
         dir_up_r <= step_up;
         quick_adapt_o <= quick_nxt;
      end
   end

   // Gray copy for the readback crossing
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         gain_gray_r <= 5'h00;
      end else begin
         gain_gray_r <= gain_code_o ^ (gain_code_o >> 1);
      end
   end

   //==========================================================================
   // Wake output; a trip in the clearing cycle still sets the latch
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         wake_o <= 1'b0;
      end else if (raw_bit) begin
         wake_o <= cmp_s;
      end else if (cmp_s && sense_on) begin
         wake_o <= 1'b1;
      end else if ((mode_s && !mode_prev_r) || clear_bit) begin
         wake_o <= 1'b0;
      end
   end

   //==========================================================================
   // Self-test state machine and 1 kHz toggle
   awcb_st_t st_state_r;
   logic [31:0] st_cnt_r;
   logic st_want;

   assign st_want = !mode_s && st_on;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         st_state_r <= ST_OFF;
      end else begin
         case (st_state_r)
            ST_OFF: begin
               if (st_want) begin
                  st_state_r <= st_pol ? ST_TOGGLE : ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (!st_want) begin
                  st_state_r <= ST_OFF;
               end else if (st_pol) begin
                  st_state_r <= ST_TOGGLE;
               end
            end
            ST_TOGGLE: begin
               if (!st_want) begin
                  st_state_r <= ST_OFF;
               end else if (!st_pol) begin
                  st_state_r <= ST_HOLD;
               end
            end
            default: st_state_r <= ST_OFF;
         endcase
      end
   end

   // Half period count; output parks low outside the toggling state
   always_ff @(posedge sys_clk_i) begin
      if (srst_i || st_state_r != ST_TOGGLE) begin
         st_cnt_r <= 32'h0000_0000;
         st_toggle_o <= 1'b0;
      end else if (st_cnt_r >= ST_HALF_CYC - 1) begin
         st_cnt_r <= 32'h0000_0000;
         st_toggle_o <= ~st_toggle_o;
      end else begin
         st_cnt_r <= st_cnt_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         st_active_o <= 1'b0;
         st_hold_cm_o <= 1'b0;
      end else begin
         st_active_o <= st_state_r != ST_OFF;
         st_hold_cm_o <= st_state_r == ST_HOLD;
      end
   end

   //==========================================================================
   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);

   AST_LPF_MAP: assert property (
      1'b1 |=> lpf_corner_o == lpf_dec($past(lpf_code)))
      else $error("low-pass corner does not follow its code");
   AST_HPF_MAP: assert property (
      ##1 hpf_corner_o == awcb_hpf_t'($past(hpf_code)))
      else $error("high-pass corner does not follow its code");
   AST_QUICK_ON: assert property (
      (tif.tick && sense_on && qcnt == 2'h1 && step_up && dir_up_r &&
       run_r != 3'h0) |=> quick_adapt_o)
      else $error("quick adaptation missed after two same-way steps");
   AST_QUICK_RATE: assert property (
      quick_adapt_o |->
      tif.lim == (rate_bit ? SLOW_CYC / 2 : SLOW_CYC) / QUICK_DIV)
      else $error("quick adaptation interval is not one sixteenth");
   AST_RATE_SEL: assert property (
      (!quick_adapt_o && rate_bit) |-> tif.lim == SLOW_CYC / 2)
      else $error("fast rate bit does not halve the interval");
   AST_GAIN_LIMIT: assert property (
      (tif.tick && sense_on && floor_s <= ceil_s) |=>
      gain_code_o >= $past(floor_s) && gain_code_o <= $past(ceil_s))
      else $error("gain code stepped outside its limits");
   AST_MARGIN: assert property (
      ##1 margin_mult_o == {1'b0, $past(margin_code)} + 4'h1)
      else $error("margin multiplier is not code plus one");
   AST_ST_ENTRY: assert property (
      $rose(st_active_o) |-> $past(st_want, 2))
      else $error("self-test entered without its conditions");
   AST_ST_HOLD: assert property (
      st_hold_cm_o |-> !st_toggle_o && st_active_o)
      else $error("self-test toggles while holding common mode");
   AST_HIB_SEL: assert property (
      ##1 hibernate_o == $past(sense_on))
      else $error("hibernate mode does not follow pin and mode bit");
   AST_WAKE_HOLD: assert property (
      (wake_o && !raw_bit && !clear_bit && !mode_s) |=> wake_o)
      else $error("latched wake dropped without a clear");
   AST_QUICK_OFF: assert property (
      (qcnt == 2'h0 && tif.tick) |=> !quick_adapt_o)
      else $error("quick adaptation engaged while disabled");

   COV_QUICK: cover property ($rose(quick_adapt_o));
   COV_WAKE: cover property (!raw_bit ##1 $rose(wake_o));
   COV_TOGGLE: cover property ($rose(st_toggle_o));
endmodule

// ---- awcb_word_sync.sv ----
// Toggle-qualified word crossing from the register clock to the system clock
`timescale 1ns/10ps
`include "awcb_consts.svh"
module awcb_word_sync (
   input wire logic link_clk_i,
   input wire logic link_rst_i,
   input wire logic wr_i,
   input wire awcb_pkg::awcb_cfg_t data_i,
   input wire logic sys_clk_i,
   input wire logic srst_i,
   output awcb_pkg::awcb_cfg_t data_o
);
   import awcb_pkg::*;
   logic tgl_r;
   logic q1_r;
   logic q2_r;
   logic q3_r;

   //==========================================================================
   // Link side: flip the flag on each write, data held in the registers
   always_ff @(posedge link_clk_i) begin
      if (link_rst_i) begin
         tgl_r <= 1'b0;
      end else if (wr_i) begin
         tgl_r <= ~tgl_r;
      end
   end

   //==========================================================================
   // System side: capture only after the flag has settled, data is static
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         q1_r <= 1'b0;
         q2_r <= 1'b0;
         q3_r <= 1'b0;
         data_o <= {`AWCB_RST_STEST, `AWCB_RST_MARGIN, `AWCB_RST_CEIL,
                    `AWCB_RST_FLOOR, `AWCB_RST_FILT, `AWCB_RST_CTRL};
      end else begin
         q1_r <= tgl_r;
         q2_r <= q1_r;
         q3_r <= q2_r;
         if (q2_r != q3_r) begin
            data_o <= data_i;
         end
      end
   end
endmodule

// ---- test_adaptive_wake_config_bist.sv ----
// Self-checking bench of the wake configuration block
`timescale 1ns/10ps
module test_adaptive_wake_config_bist;
   import awcb_pkg::*;
   typedef struct {int sel; logic [7:0] exp;} awcb_note_t;
   logic sys_clk_i = 1'b0, lclk = 1'b0, srst_i = 1'b1;
   logic mp = 1'b1, ab = 1'b0, bl = 1'b0, cmp = 1'b0;
   logic wr, q, hib, wake, sta, stc, stt;
   logic [2:0] addr;
   logic [7:0] wd, rdata, m;
   logic [3:0] mult;
   logic [4:0] gain;
   awcb_lpf_t lpf;
   awcb_hpf_t hpf;
   awcb_note_t notes[$];
   event smp;
   int fail_count = 0, checks = 0, seed = 86, n, gc;
   logic [2:0] lc[5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
   //==========
   // Clocks of unrelated phase
   always #12.5 sys_clk_i = ~sys_clk_i;
   always #80 lclk = ~lclk;
   awcb_host host (.link_clk_i(lclk), .reg_wr_o(wr),
      .reg_addr_o(addr), .reg_wdata_o(wd));
   awcb_top #(.SLOW_CYC(64), .QUICK_DIV(16), .ST_HALF_CYC(8)) DUT (
      .sys_clk_i(sys_clk_i), .srst_i(srst_i), .link_clk_i(lclk),
      .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wd),
      .mode_pin_i(mp), .win_above_i(ab), .win_below_i(bl),
      .wake_cmp_i(cmp), .reg_rdata_o(rdata), .lpf_corner_o(lpf),
      .hpf_corner_o(hpf), .margin_mult_o(mult), .gain_code_o(gain),
      .quick_adapt_o(q), .hibernate_o(hib), .wake_o(wake),
      .st_active_o(sta), .st_hold_cm_o(stc), .st_toggle_o(stt));
   //==========
   // Observed value by selector
   function automatic logic [7:0] seen(int s);
      case (s)
         0: seen = rdata;
         1: seen = 8'(lpf);
         2: seen = 8'(hpf);
         3: seen = 8'(mult);
         4: seen = 8'(gain);
         5: seen = 8'(q);
         6: seen = 8'(hib);
         7: seen = 8'(wake);
         8: seen = 8'(sta);
         9: seen = 8'(stc);
         10: seen = 8'(stt);
         default: seen = 8'(gc);
      endcase
   endfunction
   task automatic check(int s, logic [7:0] v, logic [7:0] e);
      checks++;
      if (v !== e) begin
         fail_count++;
         $display("wrong value sel %0d expected %h seen %h", s, e, v);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Driver notes the expectation; the monitor compares it
   task automatic ex(int s, logic [7:0] e);
      notes.push_back('{s, e});
      -> smp;
      #1;
   endtask
   always @(smp) begin
      awcb_note_t t;
      t = notes.pop_front();
      check(t.sel, seen(t.sel), t.exp);
   end
   //==========
   // Helpers
   task automatic cyc(int k);
      repeat (k) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic pins(logic a, logic b, logic c, logic d);
      @(posedge sys_clk_i);
      mp <= a;
      ab <= b;
      bl <= c;
      cmp <= d;
   endtask
   task automatic w(logic [2:0] a, logic [7:0] d);
      host.wr(a, d);
      cyc(10);
   endtask
   // Bounded wait; running out counts as a mismatch
   task automatic wait_for(int s, logic [7:0] v, int lim);
      n = 0;
      while (seen(s) !== v && n < lim) begin
         cyc(1);
         n++;
      end
      if (seen(s) !== v) begin
         fail_count++;
         results();
      end
   endtask
   // Cycles between two gain steps
   task automatic gap(logic [7:0] e);
      logic [4:0] g;
      g = gain;
      wait_for(4, 8'(g + 5'h01), 200);
      g = gain;
      gc = 0;
      while (gain === g && gc < 200) begin
         cyc(1);
         gc++;
      end
      ex(11, e);
   endtask
   //==========
   // Main sequence
   initial begin
      repeat (5) @(posedge lclk);
      @(posedge sys_clk_i) srst_i <= 1'b0;
      cyc(2);
      ex(4, 8'h1B);
      ex(3, 8'h01);
      repeat (3) @(posedge lclk);
      host.rd(3'h4);
      ex(0, 8'h1B);
      w(3'h7, 8'hFF);
      host.rd(3'h7);
      ex(0, 8'h00);
      foreach (lc[i]) begin
         w(3'h2, {3'h0, 2'(i), lc[i]});
         ex(1, 8'(i));
         ex(2, 8'(i % 4));
      end
      repeat (8) begin
         m = 8'(1 + {$random(seed)} % 7);
         w(3'h5, m);
         ex(3, m + 8'h01);
      end
      w(3'h5, 8'h07);
      ex(3, 8'h08);
      w(3'h6, 8'h01);
      ex(8, 8'h00);
      pins(0, 0, 0, 0);
      cyc(6);
      ex(8, 8'h01);
      ex(9, 8'h01);
      w(3'h6, 8'h03);
      wait_for(10, 8'h01, 40);
      cyc(4);
      ex(10, 8'h01);
      cyc(8);
      ex(10, 8'h00);
      w(3'h6, 8'h00);
      w(3'h0, 8'h20);
      ex(6, 8'h01);
      pins(0, 0, 0, 1);
      cyc(4);
      pins(0, 0, 0, 0);
      cyc(6);
      ex(7, 8'h01);
      pins(1, 0, 0, 0);
      cyc(6);
      ex(7, 8'h00);
      ex(6, 8'h00);
      pins(0, 0, 0, 1);
      w(3'h0, 8'h08);
      ex(6, 8'h00);
      ex(7, 8'h01);
      pins(0, 0, 0, 0);
      cyc(6);
      ex(7, 8'h00);
      // Latch a trip again, then drop it with the clear bit
      w(3'h0, 8'h20);
      pins(0, 0, 0, 1);
      cyc(4);
      pins(0, 0, 0, 0);
      cyc(6);
      ex(7, 8'h01);
      w(3'h0, 8'h30);
      ex(7, 8'h00);
      w(3'h0, 8'h00);
      // Loop runs only while sensing, so retune with it stopped
      w(3'h3, 8'h38);
      w(3'h4, 8'h3F);
      pins(0, 0, 1, 0);
      w(3'h0, 8'h20);
      wait_for(5, 8'h01, 200);
      ex(4, 8'h1D);
      cyc(8);
      ex(4, 8'h1F);
      cyc(40);
      ex(4, 8'h1F);
      pins(0, 1, 0, 0);
      wait_for(4, 8'h18, 400);
      cyc(100);
      ex(4, 8'h18);
      host.rd(3'h1);
      ex(0, 8'h18);
      w(3'h0, 8'h00);
      w(3'h3, 8'h00);
      w(3'h4, 8'h1F);
      pins(0, 0, 1, 0);
      w(3'h0, 8'h20);
      gap(8'd64);
      gap(8'd64);
      w(3'h0, 8'h00);
      w(3'h4, 8'h3F);
      w(3'h0, 8'h20);
      gap(8'd32);
      results();
   end
endmodule
